// ==== asp_pkg.sv ====
// shared constants, types and states for the async serial port core
package asp_pkg;

  // ------------------------------------------------------------
  // register addresses on the internal bus
  // ------------------------------------------------------------
  localparam logic [15:0] ADDR_MODE    = 16'hff50;
  localparam logic [15:0] ADDR_TX_BUF  = 16'hff51;
  localparam logic [15:0] ADDR_RX_BUF  = 16'hff52;
  localparam logic [15:0] ADDR_ERR_ST  = 16'hff53;
  localparam logic [15:0] ADDR_TX_ST   = 16'hff55;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] MODE_RST   = 8'h01;
  localparam logic [7:0] BUF_RST    = 8'hff;
  localparam logic [7:0] READ_ZERO  = 8'h00;

  // ------------------------------------------------------------
  // mode register field positions
  // ------------------------------------------------------------
  localparam int MODE_POWER  = 7;
  localparam int MODE_TXE    = 6;
  localparam int MODE_RXE    = 5;
  localparam int MODE_PAR_HI = 4;
  localparam int MODE_PAR_LO = 3;
  localparam int MODE_CL     = 2;
  localparam int MODE_SL     = 1;
  localparam int MODE_ROUTE  = 0;

  // parity field codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  // base clock ticks per serial bit
  localparam int BIT_DIV_DEF = 16;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  wmask;
    logic        we;
    logic        re;
  } asp_bus_s;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_PAR   = 5'h08,
    TX_STOP  = 5'h10
  } asp_tx_e;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } asp_rx_e;

endpackage : asp_pkg

// ==== asp_core.sv ====
// async serial port core: mode register, buffers, shift registers
`timescale 1ns/1ps
//
// Contract
// - receive buffer loads each finished character while not full, read-only, resets to ff
// - 7-bit lsb-first fills bits 0..6; msb-first fills bits 1..7, spare bit zero
// - overrun keeps the old receive buffer, new character dropped
// - writing transmit buffer starts sending; readable, writable, resets to ff
// - shift register loads on the next base tick when idle, or in the same cycle as the frame-done irq when chained
// - shift loads and pin bits change on base clock falling-edge ticks
// - mode register at ff50, resets 01, bit or byte writable
// - power off clears status, receive buffer and resets both engines
// - clearing transmit or receive enable resets that direction
// - power off drives transmit pin high and forces receive input high
// - parity field: none, zero, odd, even
// - zero parity is never checked and never flags an error
// - char length bit selects 7 or 8 data bits both ways
// - transmitter sends one or two stops; receiver checks only one
// - routing bit sends errors to error irq or to normal receive irq
// - low receive level with power and enable set starts a reception
// - overrun flags when a character finishes while buffer is unread
module asp_core #(
  parameter int BIT_DIV = asp_pkg::BIT_DIV_DEF  // base ticks per bit
) (
  input  wire logic             clk_i,          // system clock
  input  wire logic             rst_n_i,        // sync reset, active low
  input  wire asp_pkg::asp_bus_s bus_i,         // internal bus request
  input  wire logic             base_tick_i,    // base clock falling edge
  input  wire logic             msb_first_i,    // bit order select
  input  wire logic             receive_pin_i,  // serial input
  output logic [7:0]            rdata_o,        // read data, next cycle
  output logic                  transmit_pin_o, // serial output
  output logic                  tx_done_irq_o,  // frame sent pulse
  output logic                  rx_done_irq_o,  // character received pulse
  output logic                  rx_err_irq_o    // receive error pulse
);

  localparam int CW = $clog2(BIT_DIV) + 1;
  localparam logic [CW-1:0] LAST = CW'(BIT_DIV - 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_DIV / 2 - 1);

  logic [7:0]       mode;
  logic [7:0]       tx_buf;
  logic [7:0]       rx_buf;
  logic             tx_full;
  logic [7:0]       tx_shift;
  logic [CW-1:0]    tx_cnt;
  logic [2:0]       tx_idx;
  logic             tx_par;
  asp_pkg::asp_tx_e tx_st;
  logic             rx_full;
  logic [7:0]       rx_shift;
  logic [CW-1:0]    rx_cnt;
  logic [2:0]       rx_idx;
  logic             rx_par;
  logic             rx_perr;
  asp_pkg::asp_rx_e rx_st;
  logic             ovr_flag;
  logic             par_flag;
  logic             frm_flag;

  // ------------------------------------------------------------
  // decoded controls
  // ------------------------------------------------------------
  logic       pwr, txe, rxe, cl8, sl2, route;
  logic [1:0] par_mode;
  logic       wr_mode, wr_tx, rd_rx, rd_err;
  logic       tx_wr, tx_bit, rx_in, rx_fin, rx_ferr;
  logic [2:0] last_idx;
  logic [7:0] rx_word;

  assign pwr      = mode[asp_pkg::MODE_POWER];
  assign txe      = mode[asp_pkg::MODE_TXE];
  assign rxe      = mode[asp_pkg::MODE_RXE];
  assign par_mode = mode[asp_pkg::MODE_PAR_HI:asp_pkg::MODE_PAR_LO];
  assign cl8      = mode[asp_pkg::MODE_CL];
  assign sl2      = mode[asp_pkg::MODE_SL];
  assign route    = mode[asp_pkg::MODE_ROUTE];
  assign last_idx = cl8 ? 3'h7 : 3'h6;

  // address decode; side effects need the strobe
  assign wr_mode = bus_i.we && bus_i.addr == asp_pkg::ADDR_MODE;
  assign wr_tx   = bus_i.we && bus_i.addr == asp_pkg::ADDR_TX_BUF;
  assign rd_rx   = bus_i.re && bus_i.addr == asp_pkg::ADDR_RX_BUF;
  assign rd_err  = bus_i.re && bus_i.addr == asp_pkg::ADDR_ERR_ST;
  assign tx_wr   = wr_tx && pwr && txe;

  // powered-down input reads as idle line
  assign rx_in = pwr ? receive_pin_i : 1'b1;

  // ------------------------------------------------------------
  // mode register
  // ------------------------------------------------------------
  // masked merge lets one bit change without touching the rest
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode <= asp_pkg::MODE_RST;
    end else if (wr_mode) begin
      mode <= (mode & ~bus_i.wmask) | (bus_i.wdata & bus_i.wmask);
    end
  end

  // ------------------------------------------------------------
  // transmit buffer
  // ------------------------------------------------------------
  // stores even when disabled so software can preload it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_buf <= asp_pkg::BUF_RST;
    end else if (wr_tx) begin
      tx_buf <= bus_i.wdata;
    end
  end

  // bit about to leave, in the selected order
  assign tx_bit = msb_first_i ? tx_shift[7] : tx_shift[0];

  // ------------------------------------------------------------
  // transmit engine
  // ------------------------------------------------------------
  // pin changes wait for a base tick unless a disable forces the pin high; writes in between are kept
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !pwr || !txe) begin
      tx_st          <= asp_pkg::TX_IDLE;
      tx_full        <= 1'b0;
      tx_shift       <= asp_pkg::BUF_RST;
      tx_cnt         <= '0;
      tx_idx         <= 3'h0;
      tx_par         <= 1'b0;
      transmit_pin_o <= 1'b1;
      tx_done_irq_o  <= 1'b0;
    end else begin
      tx_done_irq_o <= 1'b0;
      if (tx_wr) begin
        tx_full <= 1'b1;
      end
      case (tx_st)
        asp_pkg::TX_IDLE: begin
          if (tx_full && base_tick_i) begin
            tx_shift       <= tx_buf;
            tx_full        <= tx_wr;
            tx_cnt         <= '0;
            transmit_pin_o <= 1'b0;
            tx_st          <= asp_pkg::TX_START;
          end
        end
        default: begin
          if (base_tick_i && tx_cnt != LAST) begin
            tx_cnt <= tx_cnt + CW'(1);
          end else if (base_tick_i) begin
            tx_cnt <= '0;
            case (tx_st)
              asp_pkg::TX_START: begin
                transmit_pin_o <= tx_bit;
                tx_par         <= tx_bit;
                tx_shift       <= msb_first_i ? {tx_shift[6:0], 1'b0}
                                              : {1'b0, tx_shift[7:1]};
                tx_idx         <= 3'h0;
                tx_st          <= asp_pkg::TX_DATA;
              end
              asp_pkg::TX_DATA: begin
                if (tx_idx != last_idx) begin
                  transmit_pin_o <= tx_bit;
                  tx_par         <= tx_par ^ tx_bit;
                  tx_shift       <= msb_first_i ? {tx_shift[6:0], 1'b0}
                                                : {1'b0, tx_shift[7:1]};
                  tx_idx         <= tx_idx + 3'h1;
                end else if (par_mode == asp_pkg::PAR_NONE) begin
                  transmit_pin_o <= 1'b1;
                  tx_idx         <= 3'h0;
                  tx_st          <= asp_pkg::TX_STOP;
                end else begin
                  // zero parity sends a constant low bit
                  case (par_mode)
                    asp_pkg::PAR_ODD:  transmit_pin_o <= ~tx_par;
                    asp_pkg::PAR_EVEN: transmit_pin_o <= tx_par;
                    default:           transmit_pin_o <= 1'b0;
                  endcase
                  tx_st <= asp_pkg::TX_PAR;
                end
              end
              asp_pkg::TX_PAR: begin
                transmit_pin_o <= 1'b1;
                tx_idx         <= 3'h0;
                tx_st          <= asp_pkg::TX_STOP;
              end
              default: begin
                if (sl2 && tx_idx == 3'h0) begin
                  tx_idx <= 3'h1;
                end else begin
                  tx_done_irq_o <= 1'b1;
                  // chained frame: reload in the cycle of the done pulse
                  if (tx_full) begin
                    tx_shift       <= tx_buf;
                    tx_full        <= tx_wr;
                    transmit_pin_o <= 1'b0;
                    tx_st          <= asp_pkg::TX_START;
                  end else begin
                    tx_st <= asp_pkg::TX_IDLE;
                  end
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // receive engine
  // ------------------------------------------------------------
  // start bit is re-checked at mid-bit so a glitch does not frame
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !pwr || !rxe) begin
      rx_st    <= asp_pkg::RX_IDLE;
      rx_shift <= asp_pkg::BUF_RST;
      rx_cnt   <= '0;
      rx_idx   <= 3'h0;
      rx_par   <= 1'b0;
      rx_perr  <= 1'b0;
    end else if (base_tick_i) begin
      rx_cnt <= rx_cnt + CW'(1);
      case (rx_st)
        asp_pkg::RX_IDLE: begin
          rx_cnt <= '0;
          if (!rx_in) begin
            rx_st <= asp_pkg::RX_START;
          end
        end
        asp_pkg::RX_START: begin
          if (rx_cnt == HALF) begin
            rx_cnt  <= '0;
            rx_idx  <= 3'h0;
            rx_par  <= 1'b0;
            rx_perr <= 1'b0;
            rx_st   <= rx_in ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA;
          end
        end
        asp_pkg::RX_DATA: begin
          if (rx_cnt == LAST) begin
            rx_cnt   <= '0;
            rx_par   <= rx_par ^ rx_in;
            rx_shift <= msb_first_i ? {rx_shift[6:0], rx_in}
                                    : {rx_in, rx_shift[7:1]};
            rx_idx   <= rx_idx + 3'h1;
            if (rx_idx == last_idx) begin
              rx_st <= (par_mode == asp_pkg::PAR_NONE) ? asp_pkg::RX_STOP
                                                       : asp_pkg::RX_PAR;
            end
          end
        end
        asp_pkg::RX_PAR: begin
          if (rx_cnt == LAST) begin
            rx_cnt <= '0;
            // zero parity is taken but never judged
            case (par_mode)
              asp_pkg::PAR_ODD:  rx_perr <= ~(rx_par ^ rx_in);
              asp_pkg::PAR_EVEN: rx_perr <= rx_par ^ rx_in;
              default:           rx_perr <= 1'b0;
            endcase
            rx_st <= asp_pkg::RX_STOP;
          end
        end
        default: begin
          if (rx_cnt == LAST) begin
            rx_st <= asp_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // first stop bit sample ends the character
  assign rx_fin  = pwr && rxe && base_tick_i && rx_st == asp_pkg::RX_STOP
                   && rx_cnt == LAST;
  assign rx_ferr = !rx_in;

  // place a 7-bit character by bit order
  always_comb begin
    if (cl8) begin
      rx_word = rx_shift;
    end else if (msb_first_i) begin
      rx_word = {rx_shift[6:0], 1'b0};
    end else begin
      rx_word = {1'b0, rx_shift[7:1]};
    end
  end

  // ------------------------------------------------------------
  // receive buffer and its full marker
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !pwr) begin
      rx_buf <= asp_pkg::BUF_RST;
    end else if (rx_fin && !rx_full) begin
      rx_buf <= rx_word;
    end
  end

  // a finish in the read cycle keeps the marker set
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !pwr || !rxe) begin
      rx_full <= 1'b0;
    end else if (rx_fin) begin
      rx_full <= 1'b1;
    end else if (rd_rx) begin
      rx_full <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // error flags, cleared by reading the error status
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !pwr) begin
      ovr_flag <= 1'b0;
      par_flag <= 1'b0;
      frm_flag <= 1'b0;
    end else begin
      ovr_flag <= (rx_fin && rx_full) || (ovr_flag && !rd_err);
      par_flag <= (rx_fin && rx_perr) || (par_flag && !rd_err);
      frm_flag <= (rx_fin && rx_ferr) || (frm_flag && !rd_err);
    end
  end

  // ------------------------------------------------------------
  // receive interrupts
  // ------------------------------------------------------------
  // an error goes to exactly one of the two outputs
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_done_irq_o <= 1'b0;
      rx_err_irq_o  <= 1'b0;
    end else begin
      rx_err_irq_o  <= rx_fin && !route
                       && (rx_full || rx_perr || rx_ferr);
      rx_done_irq_o <= rx_fin && (route
                       || !(rx_full || rx_perr || rx_ferr));
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // unmapped or idle reads return zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= asp_pkg::READ_ZERO;
    end else if (bus_i.re) begin
      case (bus_i.addr)
        asp_pkg::ADDR_MODE:   rdata_o <= mode;
        asp_pkg::ADDR_TX_BUF: rdata_o <= tx_buf;
        asp_pkg::ADDR_RX_BUF: rdata_o <= rx_buf;
        asp_pkg::ADDR_ERR_ST: rdata_o <= {5'h00, par_flag, frm_flag, ovr_flag};
        asp_pkg::ADDR_TX_ST:  rdata_o <= {6'h00, tx_full,
                                          tx_st != asp_pkg::TX_IDLE};
        default:              rdata_o <= asp_pkg::READ_ZERO;
      endcase
    end else begin
      rdata_o <= asp_pkg::READ_ZERO;
    end
  end

endmodule : asp_core

// ==== asp_core_properties.sv ====
// port-level timing checks for the async serial port core
`timescale 1ns/1ps
module asp_core_properties #(
  parameter int BIT_DIV = asp_pkg::BIT_DIV_DEF  // base ticks per bit
) (
  input wire logic              clk_i,          // system clock
  input wire logic              rst_n_i,        // sync reset, active low
  input wire asp_pkg::asp_bus_s bus_i,          // bus request
  input wire logic              base_tick_i,    // base clock tick
  input wire logic              msb_first_i,    // bit order
  input wire logic              receive_pin_i,  // serial in
  input wire logic [7:0]        rdata_o,        // read data
  input wire logic              transmit_pin_o, // serial out
  input wire logic              tx_done_irq_o,  // frame sent
  input wire logic              rx_done_irq_o,  // char received
  input wire logic              rx_err_irq_o    // receive error
);
  logic [7:0] mode_q;

  // shadow of the mode register so checks know power, enables and fields
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) mode_q <= asp_pkg::MODE_RST;
    else if (bus_i.we && bus_i.addr == asp_pkg::ADDR_MODE)
      mode_q <= (mode_q & ~bus_i.wmask) | (bus_i.wdata & bus_i.wmask);
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence tx_req_s;
    bus_i.we && bus_i.addr == asp_pkg::ADDR_TX_BUF && mode_q[7] && mode_q[6];
  endsequence
  // a queued byte may wait for a whole frame ahead of it
  sequence start_bit_s;
    ##[1:200] !transmit_pin_o;
  endsequence

  tx_start_a: assert property (tx_req_s |-> start_bit_s)
    else $error("no start bit after transmit buffer write");
  idle_read_a: assert property (!bus_i.re |=> rdata_o == 8'h00)
    else $error("read data not zero without a read");
  power_pin_a: assert property (!mode_q[7] [*2] |-> transmit_pin_o)
    else $error("transmit pin low while powered off");
  power_irq_a: assert property (!mode_q[7] [*3] |->
      !tx_done_irq_o && !rx_done_irq_o && !rx_err_irq_o)
    else $error("interrupt while powered off");
  irq_excl_a: assert property (!(rx_done_irq_o && rx_err_irq_o))
    else $error("both receive interrupts at once");
  route_err_a: assert property (rx_err_irq_o |-> !mode_q[0])
    else $error("error interrupt with routing to normal interrupt");
  rx_enabled_a: assert property (rx_done_irq_o || rx_err_irq_o |->
      mode_q[7] && mode_q[5])
    else $error("receive interrupt with receiver disabled");
  stop_high_a: assert property ($rose(tx_done_irq_o) |-> $past(transmit_pin_o, 2))
    else $error("frame done without a high stop bit");
  // depth 12 assumes a tick every other cycle and four ticks a bit
  two_stops_a: assert property ($rose(tx_done_irq_o) && mode_q[1] |->
      $past(transmit_pin_o, 12))
    else $error("second stop bit missing");
endmodule : asp_core_properties

bind asp_core asp_core_properties #(.BIT_DIV(BIT_DIV)) u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .base_tick_i(base_tick_i),
  .msb_first_i(msb_first_i), .receive_pin_i(receive_pin_i), .rdata_o(rdata_o),
  .transmit_pin_o(transmit_pin_o), .tx_done_irq_o(tx_done_irq_o),
  .rx_done_irq_o(rx_done_irq_o), .rx_err_irq_o(rx_err_irq_o)
);

// ==== asp_remote_node.sv ====
// remote serial node: drives the receive line, samples the transmit line
`timescale 1ns/1ps
module asp_remote_node #(
  parameter int BIT_DIV = 4  // base ticks per bit
) (
  input  wire logic clk_i,   // system clock
  input  wire logic tick_i,  // base clock tick
  input  wire logic line_i,  // device transmit pin
  output logic      line_o   // device receive pin
);
  // idle line is high, as a pulled-up wire would be
  initial line_o = 1'b1;

  // bits go out lsb of f first, each held one bit time of ticks
  task automatic send(input logic [11:0] f, input int n);
    @(posedge clk_i);
    #1;
    for (int i = 0; i < n; i++) begin
      line_o = f[i];
      repeat (BIT_DIV) @(posedge clk_i iff tick_i);
      #1;
    end
    line_o = 1'b1;
  endtask : send

  // waits for a start bit, samples mid-bit; returns at the last sample so
  // a chained frame right behind is still caught; unknown on timeout
  task automatic grab(input int n, output logic [11:0] f);
    int k;
    k = 0;
    f = '0;
    while (line_i !== 1'b0 && k < 2000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 2000) begin
      f = 'x;
      return;
    end
    repeat (BIT_DIV / 2) @(posedge clk_i iff tick_i);
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (BIT_DIV) @(posedge clk_i iff tick_i);
      f[i] = line_i;
    end
  endtask : grab
endmodule : asp_remote_node

// ==== test_asp_core.sv ====
// self-checking bench for the async serial port core
`timescale 1ns/1ps
module test_asp_core;
  localparam int BD = 4;  // short bit time keeps the run brief
  logic              clk_i;
  logic              rst_n_i;
  asp_pkg::asp_bus_s bus_i;
  logic              base_tick_i;
  logic              msb_first_i;
  logic              rx_line;
  logic [7:0]        rdata_o;
  logic              transmit_pin_o;
  logic              tx_done_irq_o;
  logic              rx_done_irq_o;
  logic              rx_err_irq_o;
  int                num_errors;
  int                n_compared;
  int                n_done;
  int                n_err;
  int                n_tx;
  // {data, parity, 8-bit, msb-first, two stops, routing, 2'b00}
  logic [15:0]       cfg [4] = '{16'ha528, 16'h3c44, 16'h9698, 16'h5af4};

  asp_core #(.BIT_DIV(BD)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .base_tick_i(base_tick_i),
    .msb_first_i(msb_first_i), .receive_pin_i(rx_line), .rdata_o(rdata_o),
    .transmit_pin_o(transmit_pin_o), .tx_done_irq_o(tx_done_irq_o),
    .rx_done_irq_o(rx_done_irq_o), .rx_err_irq_o(rx_err_irq_o)
  );
  asp_remote_node #(.BIT_DIV(BD)) rn (
    .clk_i(clk_i), .tick_i(base_tick_i), .line_i(transmit_pin_o), .line_o(rx_line)
  );

  // clock, and a base tick every other cycle
  initial begin
    clk_i = 1'b0;
    base_tick_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) base_tick_i <= ~base_tick_i;

  // interrupt pulses are counted so no one-cycle pulse is missed
  always @(posedge clk_i) begin
    if (rx_done_irq_o === 1'b1) n_done++;
    if (rx_err_irq_o === 1'b1) n_err++;
    if (tx_done_irq_o === 1'b1) n_tx++;
  end

  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m = 8'hff);
    @(posedge clk_i);
    #1;
    bus_i = '{addr: a, wdata: d, wmask: m, we: 1'b1, re: 1'b0};
    @(posedge clk_i);
    #1;
    bus_i.we = 1'b0;
  endtask : wr

  task automatic md(input logic [7:0] v);
    wr(asp_pkg::ADDR_MODE, v);
  endtask : md

  task automatic rd8(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    bus_i.addr = a;
    bus_i.re = 1'b1;
    @(posedge clk_i);
    #1;
    bus_i.re = 1'b0;
    d = rdata_o;
  endtask : rd8

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  // polls the transmit status until the buffer is free again
  task automatic wait_free;
    logic [7:0] v;
    int         k;
    k = 0;
    do begin
      rd8(asp_pkg::ADDR_TX_ST, v);
      k++;
    end while (v[1] !== 1'b0 && k < 100);
    if (k >= 100) begin
      num_errors++;
      test_done();
    end
  endtask : wait_free

  // frame bits lsb first: start, data, parity, stops; bad flips the bit after data
  function automatic logic [11:0] mk(input logic [15:0] c, input bit bad);
    logic [11:0] f;
    int          n;
    n = c[5] ? 8 : 7;
    f = 12'hffe;
    for (int i = 0; i < n; i++) f[i+1] = c[4] ? c[15-i] : c[8+i];
    if (c[7:6] != asp_pkg::PAR_NONE)
      f[n+1] = (c[7:6] == asp_pkg::PAR_ZERO) ? 1'b0
               : (^((f >> 1) & ((12'h1 << n) - 12'h1))) ^ !c[6];
    f[n+1] = f[n+1] ^ bad;
    return f;
  endfunction : mk

  initial begin
    logic [7:0]  rv;
    logic [7:0]  m;
    logic [11:0] fr;
    logic [11:0] f2;
    int          n;
    int          ed;
    int          ee;
    ed = 0;
    ee = 0;
    rst_n_i = 1'b0;
    bus_i = '0;
    msb_first_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    rd8(asp_pkg::ADDR_MODE, rv);
    chk("mode reset", rv, asp_pkg::MODE_RST);
    rd8(asp_pkg::ADDR_TX_BUF, rv);
    chk("tx buffer reset", rv, asp_pkg::BUF_RST);
    wr(asp_pkg::ADDR_RX_BUF, 8'h12);
    rd8(asp_pkg::ADDR_RX_BUF, rv);
    chk("rx buffer read-only", rv, asp_pkg::BUF_RST);
    wr(asp_pkg::ADDR_MODE, 8'hff, 8'h80);
    rd8(asp_pkg::ADDR_MODE, rv);
    chk("mode bit write", rv, 8'h81);
    $display("register test done");
    foreach (cfg[i]) begin
      m = {3'b100, cfg[i][7:5], cfg[i][3:2]};
      msb_first_i = cfg[i][4];
      n = (cfg[i][5] ? 10 : 9) + int'(cfg[i][7:6] != 2'h0) + int'(cfg[i][3]);
      md(m);
      md(m | 8'h40);
      repeat (4) @(posedge clk_i);
      fork
        rn.grab(n, fr);
        wr(asp_pkg::ADDR_TX_BUF, cfg[i][15:8]);
      join
      chk("tx frame", fr, mk(cfg[i], 1'b0) & ((12'h1 << n) - 12'h1));
      repeat (8) @(posedge clk_i);
      md(m);
      repeat (8) @(posedge clk_i);
    end
    md(8'h84);
    md(8'hc4);
    msb_first_i = 1'b0;
    repeat (4) @(posedge clk_i);
    fork
      begin
        rn.grab(10, fr);
        rn.grab(10, f2);
      end
      begin
        wr(asp_pkg::ADDR_TX_BUF, 8'h81);
        wait_free();
        wr(asp_pkg::ADDR_TX_BUF, 8'h7e);
      end
    join
    chk("first chained frame", fr, {2'b01, 8'h81, 1'b0});
    chk("second chained frame", f2, {2'b01, 8'h7e, 1'b0});
    repeat (8) @(posedge clk_i);
    chk("tx done count", n_tx, 12'h006);
    md(8'h84);
    $display("transmit test done");
    foreach (cfg[i]) begin
      m = {3'b100, cfg[i][7:5], cfg[i][3:2]};
      msb_first_i = cfg[i][4];
      md(m);
      md(m | 8'h20);
      rn.send(mk(cfg[i], 1'b0), 12);
      rd8(asp_pkg::ADDR_RX_BUF, rv);
      fr = cfg[i][5] ? {4'h0, cfg[i][15:8]} :
           cfg[i][4] ? {4'h0, cfg[i][15:9], 1'b0} : {5'h00, cfg[i][14:8]};
      chk("rx data", rv, fr);
      rn.send(mk(cfg[i], 1'b1), 12);
      rd8(asp_pkg::ADDR_RX_BUF, rv);
      chk("rx data after error", rv, fr);
      fr = (cfg[i][7:6] == asp_pkg::PAR_ZERO) ? 12'h000
           : (cfg[i][7:6] == asp_pkg::PAR_NONE) ? 12'h002 : 12'h004;
      rd8(asp_pkg::ADDR_ERR_ST, rv);
      chk("error status", rv, fr);
      ed += 1 + int'(cfg[i][7:6] == asp_pkg::PAR_ZERO || cfg[i][2]);
      ee += int'(cfg[i][7:6] != asp_pkg::PAR_ZERO && !cfg[i][2]);
      chk("rx done count", n_done, ed);
      chk("rx error count", n_err, ee);
      md(m);
      repeat (8) @(posedge clk_i);
    end
    md(8'h84);
    md(8'ha4);
    msb_first_i = 1'b0;
    rn.send(mk(16'h1120, 1'b0), 12);
    rn.send(mk(16'h2220, 1'b0), 12);
    rd8(asp_pkg::ADDR_RX_BUF, rv);
    chk("overrun keeps data", rv, 8'h11);
    rd8(asp_pkg::ADDR_ERR_ST, rv);
    chk("overrun flag", rv, 8'h01);
    chk("overrun error irq", n_err, ee + 1);
    $display("receive test done");
    rn.send(mk(16'h3320, 1'b0), 12);
    md(8'he4);
    repeat (4) @(posedge clk_i);
    wr(asp_pkg::ADDR_TX_BUF, 8'h00);
    repeat (24) @(posedge clk_i);
    md(8'h84);
    md(8'h00);
    repeat (4) @(posedge clk_i);
    #1;
    chk("pin after power off", transmit_pin_o, 1'b1);
    rd8(asp_pkg::ADDR_RX_BUF, rv);
    chk("rx buffer after power off", rv, asp_pkg::BUF_RST);
    rd8(asp_pkg::ADDR_TX_ST, rv);
    chk("tx status after power off", rv, 8'h00);
    $display("power test done");
    test_done();
  end
endmodule : test_asp_core
